// ### src/pssp_pkg.sv
// Summary of operation
// - Reset command restores memory and control state
// - Conversion command starts pressure or temperature
// - Conversion continues while select pin released
// - Result read shifts out MSB first
// - Repeated or unconverted read returns zero
// - Read during conversion returns zero, continues
// - Calibration memory holds eight sixteen-bit words
// - Memory read: byte command, 16-bit word
// - Address fixed, low bit is inverted select
// - I2C reset command accepted at any time
// - Busy until conversion completes, then readable
// - Master clocks 24 bits after read address
// - Device waits for acknowledge after each byte
// - Memory read: write command, then read transaction
// - Protocol pin low selects SPI, high I2C
// - SPI accepts clock modes 0 and 3
// - One-byte commands: reset, read, conversions
// - Memory read commands carry word address
package pssp_pkg;

  // Data widths
  localparam int unsigned RES_W = 24;  // Conversion result width
  localparam int unsigned CAL_W = 16;  // Calibration word width
  localparam int unsigned CAL_N = 8;   // Calibration word count

  // Command encodings
  localparam logic [7:0] CMD_RESET    = 8'h1e;
  localparam logic [7:0] CMD_ADC_READ = 8'h00;
  localparam logic [3:0] CMD_CONV_P   = 4'h4;  // Upper nibble, pressure
  localparam logic [3:0] CMD_CONV_T   = 4'h5;  // Upper nibble, temperature
  localparam logic [3:0] CMD_PROM     = 4'ha;  // Upper nibble, memory read
  localparam logic [2:0] OSR_MAX      = 3'h4;  // Highest ratio code

  // Bus constants
  localparam logic [5:0] I2C_ADDR_HI = 6'h3b;  // Fixed upper address bits
  localparam logic [3:0] BYTE_BITS   = 4'h8;   // Bits per byte

  // Reset values
  localparam logic [RES_W-1:0] RES_RST = 24'h000000;
  localparam logic [CAL_W-1:0] CAL_RST = 16'h0000;

  // I2C slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_RD_ACK, ST_SKIP
  } pssp_i2c_e;

endpackage

// ### src/pssp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pin inputs
module pssp_sync #(
  parameter int unsigned W = 1  // Number of bits
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;  // First stage, read only by second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;  // Second stage
  logic [W-1:0] sync_d;

  // Per bit next values
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_comb begin
      meta_d[b] = async_i[b];
      sync_d[b] = meta_q[b];
    end
  end

  // Register both stages
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

// ### src/pssp_port.sv
`timescale 1ns/1ps
`default_nettype none
// Serial command port: SPI or I2C slave, command decode, calibration store
module pssp_port (
  input  wire logic                         sys_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         protocol_select_i,
  input  wire logic                         select_pin_n_i,
  input  wire logic                         sclk_i,
  input  wire logic                         sdi_i,
  output logic                              sdo_o,
  input  wire logic                         sda_i,
  output logic                              sda_o,
  output logic                              sda_oe_o,
  input  wire logic [pssp_pkg::CAL_N*pssp_pkg::CAL_W-1:0] prom_data_i,
  output logic                              conv_start_o,
  output logic                              conv_temp_o,
  output logic [2:0]                        conv_oversampling_ratio_o,
  output logic                              busy_o,
  input  wire logic                         conv_done_i,
  input  wire logic [pssp_pkg::RES_W-1:0]   conv_data_i
);
  import pssp_pkg::*;

  // Synchronised pins
  logic       ps_s;      // Protocol select
  logic       csn_s;     // Select pin, active low
  logic       scl_s;     // Serial clock
  logic       sdi_s;     // SPI data in
  logic       sda_s;     // I2C data
  logic       scl_h_q;   // Clock history
  logic       scl_h_d;
  logic       sda_h_q;   // Data history
  logic       sda_h_d;
  logic       scl_rise;  // Clock rising edge
  logic       scl_fall;  // Clock falling edge
  logic       i2c_start; // Start condition
  logic       i2c_stop;  // Stop condition

  // Serial engine state
  pssp_i2c_e  st_q;      // I2C state
  pssp_i2c_e  st_d;
  logic [3:0] bit_q;     // Bit counter
  logic [3:0] bit_d;
  logic [7:0] sh_q;      // Input shift register
  logic [7:0] sh_d;
  logic [24:0] out_q;    // Output shift, bit 24 on the wire
  logic [24:0] out_d;
  logic       rw_q;      // Read transaction
  logic       rw_d;
  logic       sdo_q;     // SPI data out
  logic       sdo_d;
  logic       oe_q;      // I2C pull low
  logic       oe_d;
  logic       cmd_v;     // Command byte complete
  logic [7:0] cmd;       // Command byte
  logic       spi_load;  // Load SPI output shift

  // Command and conversion state
  logic [RES_W-1:0] res_q;  // Latest result
  logic [RES_W-1:0] res_d;
  logic [RES_W-1:0] rd_q;   // Staged answer
  logic [RES_W-1:0] rd_d;
  logic [CAL_W-1:0] cal_q [CAL_N];  // Calibration words
  logic [CAL_W-1:0] cal_d [CAL_N];
  logic       busy_q;    // Conversion running
  logic       busy_d;
  logic       bad_q;     // Running conversion corrupted
  logic       bad_d;
  logic       go_q;      // Start pulse
  logic       go_d;
  logic       temp_q;    // Temperature selected
  logic       temp_d;
  logic [2:0] osr_q;     // Ratio code
  logic [2:0] osr_d;
  logic       is_conv;   // Valid conversion command
  logic       is_prom;   // Memory read command

  // Pin synchroniser
  pssp_sync #(.W(5)) u_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({protocol_select_i, select_pin_n_i, sclk_i, sdi_i, sda_i}),
    .sync_o    ({ps_s, csn_s, scl_s, sdi_s, sda_s})
  );

  // Edge and condition detection
  always_comb begin
    scl_h_d   = scl_s;
    sda_h_d   = sda_s;
    scl_rise  = scl_s & ~scl_h_q;  // Sample edge, modes 0 and 3
    scl_fall  = ~scl_s & scl_h_q;  // Shift edge
    i2c_start = scl_s & scl_h_q & sda_h_q & ~sda_s;
    i2c_stop  = scl_s & scl_h_q & ~sda_h_q & sda_s;
  end

  // Register pin history
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_h_q <= 1'h0;
      sda_h_q <= 1'h0;
    end else begin
      scl_h_q <= scl_h_d;
      sda_h_q <= sda_h_d;
    end
  end

  // Command classes
  always_comb begin
    is_conv = (cmd[7:4] == CMD_CONV_P || cmd[7:4] == CMD_CONV_T)
              && !cmd[0] && cmd[3:1] <= OSR_MAX;
    is_prom = cmd[7:4] == CMD_PROM && !cmd[0];
  end

  // Serial engine and command execution
  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    out_d    = out_q;
    rw_d     = rw_q;
    oe_d     = oe_q;
    cmd_v    = 1'h0;
    cmd      = {sh_q[6:0], ps_s ? sda_s : sdi_s};
    spi_load = 1'h0;
    res_d    = res_q;
    rd_d     = rd_q;
    cal_d    = cal_q;
    busy_d   = busy_q;
    bad_d    = bad_q;
    go_d     = 1'h0;
    temp_d   = temp_q;
    osr_d    = osr_q;
    if (!ps_s) begin  // SPI mode
      st_d = ST_IDLE;
      oe_d = 1'h0;
      if (csn_s) begin
        // Deselected: frame ends, conversion untouched
        bit_d = 4'h0;
      end else if (scl_rise && bit_q < BYTE_BITS) begin
        sh_d  = cmd;
        bit_d = 4'(bit_q + 4'h1);
        if (bit_q == BYTE_BITS - 4'h1) begin
          cmd_v    = 1'h1;
          spi_load = 1'h1;
        end
      end else if (scl_fall && bit_q == BYTE_BITS) begin
        out_d = {out_q[23:0], 1'h0};  // MSB first
      end
    end else if (i2c_start) begin  // I2C mode
      st_d  = ST_ADDR;
      bit_d = 4'h0;
      oe_d  = 1'h0;
    end else if (i2c_stop) begin
      st_d = ST_IDLE;
      oe_d = 1'h0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_SKIP: begin
          oe_d = 1'h0;
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            sh_d  = cmd;
            bit_d = 4'(bit_q + 4'h1);
            if (bit_q == BYTE_BITS - 4'h1) begin
              bit_d = 4'h0;
              st_d  = ST_ACK;
              if (st_q == ST_WR) begin
                cmd_v = 1'h1;  // Any byte, reset included
              end else if (sh_q[6:0] == {I2C_ADDR_HI, ~csn_s}) begin
                rw_d = sda_s;
              end else begin
                st_d = ST_SKIP;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall && bit_q == 4'h0) begin
            oe_d  = 1'h1;  // Pull low for acknowledge
            bit_d = 4'h1;
          end else if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              st_d  = ST_RD;
              out_d = {rd_q, 1'h0};
              oe_d  = ~out_d[24];
            end else begin
              st_d = ST_WR;
              oe_d = 1'h0;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_d = 4'(bit_q + 4'h1);
          end else if (scl_fall && bit_q == BYTE_BITS) begin
            st_d  = ST_RD_ACK;  // Release, wait master ack
            bit_d = 4'h0;
            oe_d  = 1'h0;
          end else if (scl_fall) begin
            out_d = {out_q[23:0], 1'h0};  // MSB first
            oe_d  = ~out_d[24];
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_d = ST_SKIP;  // Not acknowledged, wait for stop
            end else begin
              bit_d = 4'h1;
            end
          end else if (scl_fall && bit_q == 4'h1) begin
            st_d  = ST_RD;  // Next byte only after ack
            bit_d = 4'h0;
            out_d = {out_q[23:0], 1'h0};
            oe_d  = ~out_d[24];
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'h0;
        end
      endcase
    end
    // Conversion completion
    if (conv_done_i && busy_q) begin
      busy_d = 1'h0;  // Result readable only now
      res_d  = bad_q ? ~conv_data_i : conv_data_i;
      bad_d  = 1'h0;
    end
    // Command execution
    if (cmd_v) begin
      if (cmd == CMD_RESET) begin
        for (int i = 0; i < CAL_N; i++) begin
          cal_d[i] = prom_data_i[i*CAL_W +: CAL_W];
        end
        res_d  = RES_RST;
        rd_d   = RES_RST;
        busy_d = 1'h0;
        bad_d  = 1'h0;
      end else if (cmd == CMD_ADC_READ) begin
        rd_d  = busy_q ? RES_RST : res_q;
        res_d = RES_RST;  // Consumed by one read
        bad_d = busy_q | bad_d;  // Conversion goes on
      end else if (is_conv) begin
        go_d   = 1'h1;
        temp_d = cmd[4];
        osr_d  = cmd[3:1];
        busy_d = 1'h1;
        bad_d  = busy_q;
      end else if (is_prom) begin
        rd_d = {cal_q[cmd[3:1]], 8'h00};
      end
    end
    if (spi_load) begin
      out_d = {1'h0, rd_d};  // MSB appears at next falling edge
    end
    sdo_d = out_d[24];
  end

  // Register engine and command state
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q   <= ST_IDLE;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      out_q  <= 25'h0;
      rw_q   <= 1'h0;
      sdo_q  <= 1'h0;
      oe_q   <= 1'h0;
      res_q  <= RES_RST;
      rd_q   <= RES_RST;
      busy_q <= 1'h0;
      bad_q  <= 1'h0;
      go_q   <= 1'h0;
      temp_q <= 1'h0;
      osr_q  <= 3'h0;
      for (int i = 0; i < CAL_N; i++) begin
        cal_q[i] <= CAL_RST;
      end
    end else begin
      st_q   <= st_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      out_q  <= out_d;
      rw_q   <= rw_d;
      sdo_q  <= sdo_d;
      oe_q   <= oe_d;
      res_q  <= res_d;
      rd_q   <= rd_d;
      busy_q <= busy_d;
      bad_q  <= bad_d;
      go_q   <= go_d;
      temp_q <= temp_d;
      osr_q  <= osr_d;
      cal_q  <= cal_d;
    end
  end

  // Outputs straight from flops; open-drain level is always low
  assign sdo_o                     = sdo_q;
  assign sda_o                     = 1'h0;
  assign sda_oe_o                  = oe_q;
  assign conv_start_o              = go_q;
  assign conv_temp_o               = temp_q;
  assign conv_oversampling_ratio_o = osr_q;
  assign busy_o                    = busy_q;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_reset_cmd;
    cmd_v && cmd == CMD_RESET |=> res_q == RES_RST && !busy_q
      && cal_q[1] == $past(prom_data_i[31:16]);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset cmd");

  property p_conv_start;
    cmd_v && is_conv |=> conv_start_o && busy_o
      && conv_temp_o == $past(cmd[4]) ##1 !conv_start_o;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conv start");

  property p_busy_hold;
    busy_q && !conv_done_i && !(cmd_v && cmd == CMD_RESET) |=> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy drop");

  property p_read_busy;
    cmd_v && cmd == CMD_ADC_READ && busy_q && !conv_done_i
      |=> rd_q == RES_RST && busy_q;
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("busy read");

  property p_read_consume;
    cmd_v && cmd == CMD_ADC_READ && !conv_done_i
      |=> rd_q == $past(busy_q ? RES_RST : res_q) && res_q == RES_RST;
  endproperty
  a_read_consume: assert property (p_read_consume) else $error("consume");

  property p_prom_word;
    cmd_v && is_prom |=> rd_q == {cal_q[$past(cmd[3:1])], 8'h00};
  endproperty
  a_prom_word: assert property (p_prom_word) else $error("prom word");

  property p_spi_msb;
    !ps_s && spi_load ##[1:7] !ps_s && !csn_s && scl_fall
      |=> sdo_o == $past(rd_q[23], 1);
  endproperty
  a_spi_msb: assert property (p_spi_msb) else $error("spi msb");

  property p_addr_ack;
    ps_s && st_q == ST_ADDR && scl_rise && bit_q == 4'h7 && !i2c_start
      && !i2c_stop && sh_q[6:0] == {I2C_ADDR_HI, ~csn_s} |=> st_q == ST_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("addr ack");

  property p_rd_wait;
    st_q == ST_RD_ACK |-> !sda_oe_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("ack wait");

  c_conv_read: cover property (busy_q ##1 !busy_q ##[1:1000] cmd_v && cmd == CMD_ADC_READ);
  c_prom_spi:  cover property (!ps_s && cmd_v && is_prom);
  c_i2c_read:  cover property (st_q == ST_RD_ACK ##[1:100] st_q == ST_RD);

endmodule
`default_nettype wire

// ### sim/pssp_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model: SPI modes 0 and 3, and I2C on the shared clock pin
module pssp_master (
  input  wire logic sys_clk_i,
  input  wire logic sdo_i,
  input  wire logic sda_oe_i,
  output logic      sclk_o,
  output logic      sel_n_o,
  output logic      sdi_o,
  output logic      sda_o
);
  logic cpol;  // Idle clock level, 1 for mode 3
  logic sda_m; // Master drive on the data wire, 1 releases it
  // Open-drain wire with pull-up
  assign sda_o = sda_m & ~sda_oe_i;
  initial begin
    cpol = 1'b0;
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
    sda_m = 1'b1;
  end
  // Wait whole system clocks
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // SPI frame: command MSB first, then n answer bits
  task automatic spi(input logic [7:0] c, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    sclk_o <= cpol;
    wt(4);
    sel_n_o <= 1'b0;
    wt(4);
    for (int i = 0; i < 8 + n; i++) begin
      sclk_o <= 1'b0;
      sdi_o <= (i < 8) ? c[7-i] : ~sdi_o;
      wt(4);
      sclk_o <= 1'b1;
      wt(4);
      if (i >= 8) rx = {rx[22:0], sdo_i};
    end
    sclk_o <= cpol;
    wt(4);
    sel_n_o <= 1'b1;
    sdi_o <= ~sdi_o;  // Released line shows no stale bit
    wt(4);
  endtask
  // I2C start: data falls while clock high
  task automatic i2c_start();
    sclk_o <= 1'b1;
    sda_m <= 1'b1;
    wt(4);
    sda_m <= 1'b0;
    wt(4);
  endtask
  // I2C stop: data rises while clock high
  task automatic i2c_stop();
    sclk_o <= 1'b0;
    wt(2);
    sda_m <= 1'b0;
    wt(2);
    sclk_o <= 1'b1;
    wt(4);
    sda_m <= 1'b1;
    wt(4);
  endtask
  // I2C byte and ninth bit; b of all ones reads, a drives the ninth bit
  task automatic i2c_byte(input logic [7:0] b, input logic a, output logic [8:0] rx);
    for (int i = 0; i < 9; i++) begin
      sclk_o <= 1'b0;
      wt(2);
      sda_m <= (i < 8) ? b[7-i] : a;
      wt(2);
      sclk_o <= 1'b1;
      wt(4);
      rx = {rx[7:0], sda_o};
    end
  endtask
endmodule
`default_nettype wire

// ### sim/pssp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial command port
module pssp_port_test;
  import pssp_pkg::*;
  logic         clk, rst, psel, select_pin_n, done;  // Clock, reset and pins
  logic [127:0] prom;                       // Calibration contents
  logic [23:0]  cdata, exp_res, rx;         // Converter data, model result, answer
  logic [16:0]  lfsr;                       // Random source state
  logic [8:0]   b;                          // Last I2C byte and ninth bit
  logic [3:0]   st;                         // Last start: kind and ratio
  logic [1:0]   ak;                         // Address and data acks
  bit           exp_busy, bad;              // Model: running, read hit it
  int           mismatches, comparisons, cnt, nst;
  wire logic    sclk, seln, sdi, sdo, sda, sda_d, sda_oe, cst, ctmp, bsy;
  wire logic [2:0] cosr;
  pssp_master MST (.sys_clk_i(clk), .sdo_i(sdo), .sda_oe_i(sda_oe), .sclk_o(sclk),
    .sel_n_o(seln), .sdi_o(sdi), .sda_o(sda));
  pssp_port DUT (.sys_clk_i(clk), .sys_rst_i(rst), .protocol_select_i(psel),
    .select_pin_n_i(psel ? select_pin_n : seln), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
    .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe), .prom_data_i(prom),
    .conv_start_o(cst), .conv_temp_o(ctmp), .conv_oversampling_ratio_o(cosr),
    .busy_o(bsy), .conv_done_i(done), .conv_data_i(cdata));
  // Next random value
  function automatic logic [16:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr;
  endfunction
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Converter model, start monitor and result model
  always @(posedge clk) begin
    if (done) begin
      exp_res = bad ? ~cdata : cdata;
      exp_busy = 1'b0;
      bad = 1'b0;
    end
    done <= 1'b0;
    if (cst) begin
      nst++;
      st = {ctmp, cosr};
      cnt = 300 + int'(rnd() & 17'h3f);
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        done <= 1'b1;
        cdata <= 24'({rnd(), rnd()});
      end
    end
  end
  // Compare and count
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // SPI conversion command and what reaches the converter
  task automatic conv(input logic [7:0] c);
    int n;
    n = nst;
    MST.spi(c, 0, rx);
    exp_busy = 1'b1;
    chk("starts", 24'(n + 1), 24'(nst));
    chk("kind", {20'h0, c[4], c[3:1]}, {20'h0, st});
    chk("busy", 24'h1, {23'h0, bsy});
  endtask
  // SPI result read against the model
  task automatic spi_read(input string nm);
    logic [23:0] e;
    e = exp_busy ? 24'h0 : exp_res;
    bad = bad | exp_busy;
    if (!exp_busy) exp_res = 24'h0;
    MST.spi(CMD_ADC_READ, 24, rx);
    chk(nm, e, rx);
  endtask
  // Wait, bounded, for the conversion to end
  task automatic wait_idle();
    int k;
    k = 0;
    while (bsy !== 1'b0 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    chk("idle", 24'h0, {23'h0, bsy});
    @(posedge clk);
  endtask
  // I2C write of one command byte to address bit a0
  task automatic i2c_cmd(input logic [7:0] c, input logic a0);
    MST.i2c_start();
    MST.i2c_byte({I2C_ADDR_HI, a0, 1'b0}, 1'b1, b);
    ak[1] = b[0];
    MST.i2c_byte(c, 1'b1, b);
    ak[0] = b[0];
    MST.i2c_stop();
  endtask
  // I2C read of n bytes, acked except the last
  task automatic i2c_rd(input int n);
    rx = 24'h0;
    MST.i2c_start();
    MST.i2c_byte({I2C_ADDR_HI, ~select_pin_n, 1'b1}, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      MST.i2c_byte(8'hff, i == n - 1, b);
      rx = {rx[15:0], b[8:1]};
    end
    MST.i2c_stop();
  endtask
  // Watchdog
  initial begin
    #4000000;
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial begin
    int n;
    lfsr = 17'h1485e;
    {mismatches, comparisons, cnt, nst} = '0;
    {exp_res, exp_busy, bad} = '0;
    {rst, psel, select_pin_n} = {1'b1, 2'h0};
    prom = 128'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    MST.spi(8'ha6, 16, rx);
    chk("prom_early", 24'h0, rx);
    MST.spi(CMD_RESET, 0, rx);
    for (int w = 0; w < 8; w++) begin
      MST.cpol = w[0];
      MST.spi({CMD_PROM, w[2:0], 1'b0}, 16, rx);
      chk("prom", {8'h0, prom[16*w +: 16]}, rx);
    end
    $display("test spi prom done");
    spi_read("no_conv");
    for (int k = 0; k < 10; k++) begin
      MST.cpol = k[0];
      conv(8'h40 + 8'(16 * (k / 5) + 2 * (k % 5)));
      wait_idle();
      spi_read("result");
      spi_read("reread");
    end
    n = nst;
    MST.spi(8'h41, 0, rx);
    MST.spi(8'h5a, 0, rx);
    chk("ignored", 24'(n), 24'(nst));
    $display("test spi conversions done");
    conv(8'h48);
    spi_read("early");
    chk("still_busy", 24'h1, {23'h0, bsy});
    wait_idle();
    spi_read("spoiled");
    $display("test read during conversion done");
    psel <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      select_pin_n <= s[0];
      repeat (4) @(posedge clk);
      n = nst;
      i2c_cmd(8'h48, select_pin_n);
      chk("wrong_addr", 24'(n), 24'(nst));
      chk("nacks", 24'h3, {22'h0, ak});
      i2c_cmd(8'h56, ~select_pin_n);
      exp_busy = 1'b1;
      chk("acks", 24'h0, {22'h0, ak});
      wait_idle();
      i2c_cmd(CMD_ADC_READ, ~select_pin_n);
      i2c_rd(3);
      chk("i2c_res", exp_res, rx);
      exp_res = 24'h0;
      i2c_cmd({CMD_PROM, 3'h3, 1'b0}, ~select_pin_n);
      i2c_rd(2);
      chk("i2c_prom", {8'h0, prom[63:48]}, rx);
    end
    i2c_cmd(8'h58, ~select_pin_n);
    i2c_cmd(CMD_RESET, ~select_pin_n);
    chk("reset_busy", 24'h0, {23'h0, bsy});
    // Read cut short, master clocks the line free, then resets
    MST.i2c_start();
    MST.i2c_byte({I2C_ADDR_HI, ~select_pin_n, 1'b1}, 1'b1, b);
    MST.i2c_byte(8'hff, 1'b1, b);
    i2c_cmd(CMD_RESET, ~select_pin_n);
    chk("bus_free", 24'h0, {20'h0, ak, sda_d, sda_oe});
    $display("test i2c done");
    end_sim();
  end
endmodule
`default_nettype wire
